// ==== common/faes_pkg.sv ====
package faes_pkg;

	// ********************************
	// Register map (byte addresses)
	// ********************************
	localparam logic [7:0] STATUS_OFFSET   = 8'h00;
	localparam logic [7:0] ENABLE_OFFSET   = 8'h04;
	localparam logic [7:0] IRQ_STAT_OFFSET = 8'h08;
	localparam logic [7:0] IRQ_CLR_OFFSET  = 8'h0C;
	localparam logic [7:0] IRQ_EN_OFFSET   = 8'h10;

	// ********************************
	// Field positions
	// ********************************
	localparam int CODE_ERR_BIT = 7;
	localparam int LOCK_BIT     = 4;
	localparam int DATA_ERR_BIT = 3;
	localparam int CORR_BIT     = 0;
	localparam logic [7:0] FLAG_MASK = 8'h99;

	// ********************************
	// Reset values
	// ********************************
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [7:0] ENABLE_RESET = 8'h00;
	localparam logic [2:0] EVENT_RESET  = 3'h0;

	// ********************************
	// Address windows (bits 18..0)
	// ********************************
	localparam logic [18:0] DATA_LIMIT_64K = 19'h1_0000;
	localparam logic [18:0] DATA_LIMIT_32K = 19'h0_8000;
	localparam logic [18:0] LOW_AREA_END   = 19'h0_003F;
	localparam logic [18:0] CFG_AREA_END   = 19'h0_00FF;
	localparam logic [18:0] OTP_AREA_END   = 19'h0_009F;

	// Command kinds from the sequencer decoder
	typedef enum logic [1:0] {
		faes_cmd_data,
		faes_cmd_config,
		faes_cmd_otp,
		faes_cmd_other
	} faes_cmd_type;

	// Command issue from the sequencer
	typedef struct packed {
		logic         issue;
		faes_cmd_type kind;
		logic [18:0]  start_addr;
	} faes_issue_type;

	// Sequencer status inputs
	typedef struct packed {
		logic config_correction_flag;
		logic table_correction_flag;
		logic otp_correction_flag;
		logic seq_ram_correction_flag;
	} faes_corr_type;

	// Read-channel holding state
	typedef enum logic [0:0] {
		faes_rd_idle,
		faes_rd_resp
	} faes_rd_state_type;

endpackage : faes_pkg

// ==== hdl/faes_top.sv ====
`timescale 1ns/10ps
module faes_top #(
	parameter bit DATA_64K = 1'b1   // Data flash is 64 KB, else 32 KB
) (
	input  wire logic                  mclk_in,           // Clock, 20 MHz
	input  wire logic                  resetn_in,         // Async reset, low
	input  wire logic [7:0]            s_axi_awaddr_in,   // Write address
	input  wire logic                  s_axi_awvalid_in,  // Write address valid
	output logic                       s_axi_awready_out, // Write address ready
	input  wire logic [31:0]           s_axi_wdata_in,    // Write data
	input  wire logic [3:0]            s_axi_wstrb_in,    // Write strobes
	input  wire logic                  s_axi_wvalid_in,   // Write data valid
	output logic                       s_axi_wready_out,  // Write data ready
	output logic [1:0]                 s_axi_bresp_out,   // Write response
	output logic                       s_axi_bvalid_out,  // Write response valid
	input  wire logic                  s_axi_bready_in,   // Write response ready
	input  wire logic [7:0]            s_axi_araddr_in,   // Read address
	input  wire logic                  s_axi_arvalid_in,  // Read address valid
	output logic                       s_axi_arready_out, // Read address ready
	output logic [31:0]                s_axi_rdata_out,   // Read data
	output logic [1:0]                 s_axi_rresp_out,   // Read response
	output logic                       s_axi_rvalid_out,  // Read data valid
	input  wire logic                  s_axi_rready_in,   // Read data ready
	input  wire faes_pkg::faes_issue_type cmd_in,         // Command issue
	input  wire logic                  data_mode_in,      // Data flash P/E mode
	input  wire logic                  code_flash_error_in, // Code flash error event
	input  wire logic                  correction_event_in, // 1-bit correction seen
	input  wire logic                  status_clear_start_in, // Status clear starts
	input  wire logic                  forced_stop_start_in,  // Forced stop starts
	input  wire faes_pkg::faes_corr_type corr_flags_in,   // Sequencer correction flags
	output logic                       illegal_error_set_out, // Set illegal-error flag
	output logic                       command_lock_out,  // Command lock state
	output logic                       flash_error_irq_out, // To error control module
	output logic                       irq_out            // Block event interrupt
);

	// ********************************
	// State
	// ********************************
	typedef struct packed {
		// Software-visible registers and their internal clear-arming markers
		logic [7:0]  status;       // Flag register
		logic [7:0]  enable;       // Interrupt enables
		logic        code_seen1;   // Code flag read as 1
		logic        data_seen1;   // Data flag read as 1
		// Write channel
		logic        aw_held;
		logic [7:0]  aw_addr;
		logic        w_held;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		logic        bvalid;
		logic [1:0]  bresp;
		// Read channel
		faes_pkg::faes_rd_state_type rd_state;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		// Block events
		logic [2:0]  ev_stat;      // Sticky events: code, data, correction
		logic [2:0]  ev_en;
		logic        ill_pulse;
	} faes_state_type;

	faes_state_type state;
	faes_state_type next_state;

	logic        data_hit;
	logic        do_write;
	logic        do_read;
	logic        set_data;
	logic        set_code;
	logic        set_corr;
	logic        clr_corr;
	logic [7:0]  wb;

	// Decoded pieces of the sequencer side
	logic        clear_or_stop;  // A clearing command starts
	logic        any_area_corr;  // Config, table or OTP correction level
	logic        ram_corr_stop;  // Forced stop with sequencer RAM correction

	// Interrupt terms, one per gated flag
	logic        code_irq;       // Code-flash error and its enable
	logic        lock_irq;       // Command lock and its enable
	logic        data_irq;       // Data-flash error and its enable
	logic        corr_irq;       // Correction flag and its enable
	logic [2:0]  event_gate;     // Block events that pass their enables

	// ********************************
	// Address checks
	// ********************************
	// Data commands only count in data programming mode
	// Config and OTP windows apply in any mode
	// Start address bits 18..0 are all that matter
	// Flag set on the edge that samples the issue pulse
	always_comb begin
		logic [18:0] a;
		a = cmd_in.start_addr;
		data_hit = 1'b0;
		case (cmd_in.kind)
			// Data area beyond the fitted size
			faes_pkg::faes_cmd_data: begin
				data_hit = data_mode_in && (a >= (DATA_64K ? faes_pkg::DATA_LIMIT_64K
					: faes_pkg::DATA_LIMIT_32K));
			end
			// Config area is 0x40..0xFF
			faes_pkg::faes_cmd_config: begin
				data_hit = (a <= faes_pkg::LOW_AREA_END)
					|| (a > faes_pkg::CFG_AREA_END);
			end
			// OTP area is 0x40..0x9F
			faes_pkg::faes_cmd_otp: begin
				data_hit = (a <= faes_pkg::LOW_AREA_END)
					|| (a > faes_pkg::OTP_AREA_END);
			end
			// Other commands never raise this flag
			default: begin
				data_hit = 1'b0;
			end
		endcase
	end

	// ********************************
	// Event terms
	// ********************************
	// Access errors from the decoder and the code flash side, and the correction event
	assign set_data = cmd_in.issue && data_hit;
	assign set_code = code_flash_error_in;
	assign set_corr = correction_event_in;

	// Correction clear conditions
	assign clear_or_stop = status_clear_start_in || forced_stop_start_in;
	assign any_area_corr = corr_flags_in.config_correction_flag
		|| corr_flags_in.table_correction_flag
		|| corr_flags_in.otp_correction_flag;
	assign ram_corr_stop = forced_stop_start_in && corr_flags_in.seq_ram_correction_flag;
	// A status clear with only the RAM correction level leaves the flag
	assign clr_corr = (clear_or_stop && any_area_corr)
		|| ram_corr_stop;

	// ********************************
	// Bus strobes
	// ********************************
	// A write runs once address and data are both held
	// It waits while the previous response is still pending
	assign do_write = state.aw_held && state.w_held && !state.bvalid;
	// A read is taken only when no read data is waiting
	assign do_read = s_axi_arvalid_in && (state.rd_state == faes_pkg::faes_rd_idle);
	// Only the low byte lane carries register bits
	assign wb = state.w_data[7:0];

	// ********************************
	// Next state
	// ********************************
	// Order inside this process matters
	// Bus effects come first, then clears, then sets
	// Every set is applied last, so an event never loses to a clear
	// The illegal-error pulse lasts exactly one cycle
	always_comb begin
		logic wr_lane0;
		logic lock_clear;
		next_state = state;
		next_state.ill_pulse = 1'b0;
		wr_lane0 = do_write && state.w_strb[0];
		lock_clear = 1'b0;

		// Write channel capture, either order
		// Each channel is held until the write runs, so its ready stays low
		if (s_axi_awvalid_in && !state.aw_held) begin
			next_state.aw_held = 1'b1;
			next_state.aw_addr = s_axi_awaddr_in;
		end
		if (s_axi_wvalid_in && !state.w_held) begin
			next_state.w_held = 1'b1;
			next_state.w_data = s_axi_wdata_in;
			next_state.w_strb = s_axi_wstrb_in;
		end
		// Execute the write and raise the response
		if (do_write) begin
			next_state.aw_held = 1'b0;
			next_state.w_held = 1'b0;
			next_state.bvalid = 1'b1;
			next_state.bresp = 2'h0;
			case (state.aw_addr)
				faes_pkg::STATUS_OFFSET, faes_pkg::ENABLE_OFFSET,
				faes_pkg::IRQ_STAT_OFFSET, faes_pkg::IRQ_CLR_OFFSET,
				faes_pkg::IRQ_EN_OFFSET: begin
					next_state.bresp = 2'h0;
				end
				default: begin
					next_state.bresp = 2'h2;
				end
			endcase
		end
		// Response leaves once the master has taken it
		if (state.bvalid && s_axi_bready_in) begin
			next_state.bvalid = 1'b0;
		end

		// Status writes: zero clears only after a read of one
		// The armed marker is set by a status read that shows one
		// A fresh error disarms it, so software must look again
		// Writes to the lock and correction bits have no effect
		if (wr_lane0 && state.aw_addr == faes_pkg::STATUS_OFFSET) begin
			if (!wb[faes_pkg::DATA_ERR_BIT] && state.data_seen1) begin
				next_state.status[faes_pkg::DATA_ERR_BIT] = 1'b0;
				next_state.data_seen1 = 1'b0;
			end
			if (!wb[faes_pkg::CODE_ERR_BIT] && state.code_seen1) begin
				next_state.status[faes_pkg::CODE_ERR_BIT] = 1'b0;
				next_state.code_seen1 = 1'b0;
			end
		end
		// Enable writes keep reserved bits at zero
		if (wr_lane0 && state.aw_addr == faes_pkg::ENABLE_OFFSET) begin
			next_state.enable = wb & faes_pkg::FLAG_MASK;
		end
		// Block event enables, then write-one-to-clear of events
		if (wr_lane0 && state.aw_addr == faes_pkg::IRQ_EN_OFFSET) begin
			next_state.ev_en = wb[2:0];
		end
		if (wr_lane0 && state.aw_addr == faes_pkg::IRQ_CLR_OFFSET) begin
			next_state.ev_stat = state.ev_stat & ~wb[2:0];
		end

		// Read channel
		// Read data is registered and held until rready is seen
		// A status read that shows an access error arms its clear
		if (do_read) begin
			next_state.rd_state = faes_pkg::faes_rd_resp;
			next_state.rresp = 2'h0;
			next_state.rdata = 32'h0000_0000;
			case (s_axi_araddr_in)
				faes_pkg::STATUS_OFFSET: begin
					next_state.rdata = {24'h00_0000, state.status & faes_pkg::FLAG_MASK};
					if (state.status[faes_pkg::DATA_ERR_BIT]) begin
						next_state.data_seen1 = 1'b1;
					end
					if (state.status[faes_pkg::CODE_ERR_BIT]) begin
						next_state.code_seen1 = 1'b1;
					end
				end
				faes_pkg::ENABLE_OFFSET: begin
					next_state.rdata = {24'h00_0000, state.enable};
				end
				faes_pkg::IRQ_STAT_OFFSET: begin
					next_state.rdata = {29'h0000_0000, state.ev_stat};
				end
				faes_pkg::IRQ_EN_OFFSET: begin
					next_state.rdata = {29'h0000_0000, state.ev_en};
				end
				faes_pkg::IRQ_CLR_OFFSET: begin
					next_state.rdata = 32'h0000_0000;
				end
				default: begin
					next_state.rresp = 2'h2;
				end
			endcase
		end else if (state.rd_state == faes_pkg::faes_rd_resp && s_axi_rready_in) begin
			next_state.rd_state = faes_pkg::faes_rd_idle;
		end

		// Correction flag: setting wins over clearing
		// The clear follows the sequencer's own correction levels
		if (clr_corr) begin
			next_state.status[faes_pkg::CORR_BIT] = 1'b0;
		end
		if (set_corr) begin
			next_state.status[faes_pkg::CORR_BIT] = 1'b1;
		end

		// Command lock leaves on clear/stop once both access errors are zero
		// The errors are looked at before this cycle's own writes land
		lock_clear = clear_or_stop
			&& !state.status[faes_pkg::DATA_ERR_BIT] && !state.status[faes_pkg::CODE_ERR_BIT];
		if (lock_clear) begin
			next_state.status[faes_pkg::LOCK_BIT] = 1'b0;
		end

		// Access errors set last so an arriving error wins over a clear
		// Each one also enters the lock and asks for the illegal-error flag
		if (set_data) begin
			next_state.status[faes_pkg::DATA_ERR_BIT] = 1'b1;
			next_state.status[faes_pkg::LOCK_BIT] = 1'b1;
			next_state.ill_pulse = 1'b1;
			next_state.data_seen1 = 1'b0;
		end
		if (set_code) begin
			next_state.status[faes_pkg::CODE_ERR_BIT] = 1'b1;
			next_state.status[faes_pkg::LOCK_BIT] = 1'b1;
			next_state.ill_pulse = 1'b1;
			next_state.code_seen1 = 1'b0;
		end

		// Sticky block events: code error, data error, correction
		// Added after the clear write, so a same-cycle event stays
		next_state.ev_stat = next_state.ev_stat | {set_code, set_data, set_corr};
	end

	// ********************************
	// Registers
	// ********************************
	// One register stage for the whole block state
	// Reset leaves all flags, enables and bus channels idle
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state          <= '0;
			state.status   <= faes_pkg::STATUS_RESET;
			state.enable   <= faes_pkg::ENABLE_RESET;
			state.ev_stat  <= faes_pkg::EVENT_RESET;
			state.ev_en    <= faes_pkg::EVENT_RESET;
			state.rd_state <= faes_pkg::faes_rd_idle;
		end else begin
			state <= next_state;
		end
	end

	// ********************************
	// Outputs
	// ********************************
	// Write channel handshakes come straight from the holding flags
	assign s_axi_awready_out = !state.aw_held;
	assign s_axi_wready_out  = !state.w_held;
	assign s_axi_bvalid_out  = state.bvalid;
	assign s_axi_bresp_out   = state.bresp;

	// Read channel stays valid until the master takes the data
	assign s_axi_arready_out = (state.rd_state == faes_pkg::faes_rd_idle);
	assign s_axi_rvalid_out  = (state.rd_state == faes_pkg::faes_rd_resp);
	assign s_axi_rdata_out   = state.rdata;
	assign s_axi_rresp_out   = state.rresp;

	// ********************************
	// Sequencer side
	// ********************************
	// One-cycle request to set the illegal-error flag
	assign illegal_error_set_out = state.ill_pulse;
	// Lock level shown to the sequencer equals status bit 4
	assign command_lock_out  = state.status[faes_pkg::LOCK_BIT];

	// ********************************
	// Interrupts
	// ********************************
	// Each flag is gated by the enable bit at the same position
	assign code_irq = state.status[faes_pkg::CODE_ERR_BIT]
		&& state.enable[faes_pkg::CODE_ERR_BIT];
	assign lock_irq = state.status[faes_pkg::LOCK_BIT]
		&& state.enable[faes_pkg::LOCK_BIT];
	assign data_irq = state.status[faes_pkg::DATA_ERR_BIT]
		&& state.enable[faes_pkg::DATA_ERR_BIT];
	assign corr_irq = state.status[faes_pkg::CORR_BIT]
		&& state.enable[faes_pkg::CORR_BIT];
	// Flash error request to the error control module
	assign flash_error_irq_out = code_irq || lock_irq || data_irq
		|| corr_irq;
	// Block event interrupt from the sticky event register
	assign event_gate = state.ev_stat & state.ev_en;
	assign irq_out = |event_gate;

endmodule : faes_top

// ==== tb/faes_monitor.sv ====
`timescale 1ns/10ps
module faes_monitor #(
	parameter bit DATA_64K = 1'b1 // Data flash size
) (
	input wire logic                     mclk_in,               // Clock
	input wire logic                     resetn_in,             // Reset
	input wire faes_pkg::faes_issue_type cmd_in,                // Command
	input wire logic                     data_mode_in,          // Data mode
	input wire logic                     code_flash_error_in,   // Code error
	input wire logic                     status_clear_start_in, // Clear start
	input wire logic                     forced_stop_start_in,  // Stop start
	input wire logic                     illegal_error_set_out, // Illegal pulse
	input wire logic                     command_lock_out,      // Lock
	input wire logic                     s_axi_bvalid_out,      // B valid
	input wire logic                     s_axi_bready_in        // B ready
);
	// ********************************
	// Bad command decode
	// ********************************
	logic [18:0] a;
	logic        bad_d;
	logic        bad_c;
	logic        bad_o;
	assign a = cmd_in.start_addr;
	assign bad_d = cmd_in.issue && cmd_in.kind == faes_pkg::faes_cmd_data && data_mode_in
		&& a >= (DATA_64K ? 19'h1_0000 : 19'h0_8000);
	assign bad_c = cmd_in.issue && cmd_in.kind == faes_pkg::faes_cmd_config
		&& (a <= 19'h0_003F || a >= 19'h0_0100);
	assign bad_o = cmd_in.issue && cmd_in.kind == faes_pkg::faes_cmd_otp
		&& (a <= 19'h0_003F || a >= 19'h0_00A0);

	// ********************************
	// Properties
	// ********************************
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!resetn_in);
	sequence s_first(x);
		x && !command_lock_out;
	endsequence
	sequence s_flag;
		illegal_error_set_out && command_lock_out;
	endsequence
	AST_DATA_RANGE: assert property (s_first(bad_d) |=> s_flag)
		else $error("data range");
	AST_CFG_RANGE: assert property (s_first(bad_c) |=> s_flag)
		else $error("config range");
	AST_OTP_RANGE: assert property (s_first(bad_o) |=> s_flag)
		else $error("otp range");
	AST_CODE_ERR: assert property (s_first(code_flash_error_in) |=> s_flag)
		else $error("code error");
	AST_NO_CAUSE: assert property (!(bad_d || bad_c || bad_o || code_flash_error_in)
		|=> !illegal_error_set_out) else $error("spurious pulse");
	AST_LOCK_RISE: assert property ($rose(command_lock_out) |-> illegal_error_set_out)
		else $error("lock rise");
	AST_LOCK_FALL: assert property ($fell(command_lock_out)
		|-> $past(status_clear_start_in || forced_stop_start_in)) else $error("lock fall");
	AST_BDONE: assert property (s_axi_bvalid_out && s_axi_bready_in |=> !s_axi_bvalid_out)
		else $error("bvalid held");
endmodule : faes_monitor

bind faes_top faes_monitor #(.DATA_64K(DATA_64K)) u_mon (.mclk_in, .resetn_in, .cmd_in,
	.data_mode_in, .code_flash_error_in, .status_clear_start_in, .forced_stop_start_in,
	.illegal_error_set_out, .command_lock_out, .s_axi_bvalid_out, .s_axi_bready_in);

// ==== tb/faes_seq_model.sv ====
`timescale 1ns/10ps
module faes_seq_model (
	input wire logic                 mclk_in,  // Clock
	output faes_pkg::faes_issue_type cmd_out,  // Command issue
	output logic                     mode_out, // Data mode level
	output logic [3:0]               ev_out,   // Stop, clear, corr, code pulses
	output faes_pkg::faes_corr_type  flags_out // Correction levels
);
	// Idle values
	initial begin
		cmd_out = '0;
		mode_out = 1'b0;
		ev_out = 4'h0;
		flags_out = '0;
	end

	// One-cycle command issue; released lines show garbage
	task automatic issue(input faes_pkg::faes_cmd_type k, input logic [18:0] ad, input logic m);
		@(posedge mclk_in);
		cmd_out <= {1'b1, k, ad};
		mode_out <= m;
		@(posedge mclk_in);
		cmd_out <= {1'b0, faes_pkg::faes_cmd_other, ~ad};
	endtask : issue

	// One-cycle event pulses; flag levels stay
	task automatic fire(input logic [3:0] e, input faes_pkg::faes_corr_type f);
		@(posedge mclk_in);
		ev_out <= e;
		flags_out <= f;
		@(posedge mclk_in);
		ev_out <= 4'h0;
		@(negedge mclk_in);
	endtask : fire
endmodule : faes_seq_model

// ==== tb/faes_top_tb.sv ====
`timescale 1ns/10ps
module faes_top_tb;
	logic                     mclk_in, resetn_in, awvalid, wvalid, bready, arvalid, rready;
	logic                     awready, wready, bvalid, arready, rvalid, lock, ferr, irq, mode;
	logic [7:0]               awaddr, araddr;
	logic [31:0]              wdata, rdata, got;
	logic [1:0]               bresp, rresp, bs;
	logic [3:0]               ev;
	faes_pkg::faes_issue_type cmd;
	faes_pkg::faes_corr_type  flags;
	logic [18:0]              ads [11] = '{19'h0_FFFF, 19'h1_0000, 19'h7_FFFF, 19'h0_003F,
		19'h0_0040, 19'h0_00FF, 19'h0_0100, 19'h0_003F, 19'h0_0040, 19'h0_009F, 19'h0_00A0};
	logic [10:0]              bad = 11'h4CA;
	int                       n_errors = 0, n_tests = 0, cyc = 0;

	faes_seq_model u_seq (.mclk_in(mclk_in), .cmd_out(cmd), .mode_out(mode), .ev_out(ev),
		.flags_out(flags));
	faes_top u_dut (.mclk_in(mclk_in), .resetn_in(resetn_in), .s_axi_awaddr_in(awaddr),
		.s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
		.s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
		.s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
		.s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
		.s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
		.s_axi_rready_in(rready), .cmd_in(cmd), .data_mode_in(mode),
		.code_flash_error_in(ev[0]), .correction_event_in(ev[1]), .status_clear_start_in(ev[2]),
		.forced_stop_start_in(ev[3]), .corr_flags_in(flags), .illegal_error_set_out(),
		.command_lock_out(lock), .flash_error_irq_out(ferr), .irq_out(irq));

	// ********************************
	// Checks and bus tasks
	// ********************************
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %s: expected %h, seen %h", n, e, g);
		end
	endtask : chk

	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		logic ta, tw, tb;
		tb = 1'b0;
		@(posedge mclk_in);
		awaddr <= ad;
		wdata <= d;
		{awvalid, wvalid, bready} <= 3'h7;
		while (!tb) begin
			@(negedge mclk_in);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bvalid && bready;
			bs = bresp;
			@(posedge mclk_in);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
		end
		bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] ad, input logic [31:0] e);
		logic ta, tr;
		tr = 1'b0;
		@(posedge mclk_in);
		araddr <= ad;
		{arvalid, rready} <= 2'h3;
		while (!tr) begin
			@(negedge mclk_in);
			ta = arvalid && arready;
			tr = rvalid && rready;
			got = rdata;
			@(posedge mclk_in);
			if (ta) arvalid <= 1'b0;
		end
		rready <= 1'b0;
		chk($sformatf("reg %h", ad), e, got);
	endtask : rd

	task automatic finish_test;
		$display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : finish_test

	// ********************************
	// Clock, timeout and main sequence
	// ********************************
	initial begin
		mclk_in = 1'b0;
		forever #25 mclk_in = ~mclk_in;
	end

	always @(posedge mclk_in) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			finish_test();
		end
	end

	initial begin
		{resetn_in, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
		{awaddr, araddr, wdata} = '0;
		repeat (20) @(posedge mclk_in);
		resetn_in <= 1'b1;
		rd(faes_pkg::STATUS_OFFSET, 32'h0);
		wr(8'h14, 32'h0);
		chk("bresp", 32'h2, {30'h0, bs});
		wr(faes_pkg::ENABLE_OFFSET, 32'h99);
		rd(faes_pkg::ENABLE_OFFSET, 32'h99);
		wr(faes_pkg::ENABLE_OFFSET, 32'h08);
		// Address windows of data, config and OTP commands
		for (int i = 0; i < 11; i++) begin
			u_seq.issue(faes_pkg::faes_cmd_type'(i < 3 ? 0 : i < 7 ? 1 : 2), ads[i], i != 2);
			rd(faes_pkg::STATUS_OFFSET, bad[i] ? 32'h18 : 32'h0);
			chk("flash irq", {31'h0, bad[i]}, {31'h0, ferr});
			if (bad[i]) begin
				wr(faes_pkg::STATUS_OFFSET, 32'h0);
				u_seq.fire(i[0] ? 4'h4 : 4'h8, '0);
				rd(faes_pkg::STATUS_OFFSET, 32'h0);
			end
		end
		// Clear needs a prior read of one; lock enable
		u_seq.issue(faes_pkg::faes_cmd_data, 19'h1_0000, 1'b1);
		wr(faes_pkg::STATUS_OFFSET, 32'h0);
		rd(faes_pkg::STATUS_OFFSET, 32'h18);
		wr(faes_pkg::STATUS_OFFSET, 32'h0);
		rd(faes_pkg::STATUS_OFFSET, 32'h10);
		wr(faes_pkg::ENABLE_OFFSET, 32'h10);
		chk("flash irq", 32'h1, {31'h0, ferr});
		wr(faes_pkg::ENABLE_OFFSET, 32'h0);
		chk("flash irq", 32'h0, {31'h0, ferr});
		u_seq.fire(4'h8, '0);
		chk("lock", 32'h0, {31'h0, lock});
		// Code flash error
		u_seq.fire(4'h1, '0);
		rd(faes_pkg::STATUS_OFFSET, 32'h90);
		chk("flash irq", 32'h0, {31'h0, ferr});
		wr(faes_pkg::ENABLE_OFFSET, 32'h80);
		chk("flash irq", 32'h1, {31'h0, ferr});
		wr(faes_pkg::STATUS_OFFSET, 32'h0);
		u_seq.fire(4'h4, '0);
		rd(faes_pkg::STATUS_OFFSET, 32'h0);
		// Correction flag and event interrupt
		rd(faes_pkg::IRQ_STAT_OFFSET, 32'h6);
		chk("irq", 32'h0, {31'h0, irq});
		wr(faes_pkg::IRQ_CLR_OFFSET, 32'h7);
		wr(faes_pkg::IRQ_EN_OFFSET, 32'h7);
		wr(faes_pkg::ENABLE_OFFSET, 32'h1);
		u_seq.fire(4'h2, '0);
		rd(faes_pkg::STATUS_OFFSET, 32'h1);
		chk("flash irq", 32'h1, {31'h0, ferr});
		chk("irq", 32'h1, {31'h0, irq});
		rd(faes_pkg::IRQ_STAT_OFFSET, 32'h1);
		wr(faes_pkg::IRQ_EN_OFFSET, 32'h0);
		chk("irq", 32'h0, {31'h0, irq});
		wr(faes_pkg::IRQ_CLR_OFFSET, 32'h1);
		rd(faes_pkg::IRQ_STAT_OFFSET, 32'h0);
		u_seq.fire(4'h4, 4'h1);
		rd(faes_pkg::STATUS_OFFSET, 32'h1);
		u_seq.fire(4'h4, 4'h4);
		rd(faes_pkg::STATUS_OFFSET, 32'h0);
		u_seq.fire(4'h2, 4'h0);
		rd(faes_pkg::STATUS_OFFSET, 32'h1);
		u_seq.fire(4'h8, 4'h1);
		rd(faes_pkg::STATUS_OFFSET, 32'h0);
		finish_test();
	end
endmodule : faes_top_tb
